/* psrw_cpu_model.sv */
// Processor model that kicks the watchdog strobe while out of reset
module psrw_cpu_model (
   // Clock and supervisor reset
   input  wire logic       clk_sys,
   input  wire logic       reset_out_n,
   // Kick control from the bench
   input  wire logic       kick_en,
   input  wire logic [7:0] kick_period,
   // Strobe towards the supervisor
   output      logic       strobe_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int   cnt;
   logic en;
   // Enable is sampled on the edge so the bench's own drive cannot race it
   initial begin
      strobe_out = 1'b0;
      cnt        = 0;
      forever begin
         @(posedge clk_sys);
         en = kick_en && reset_out_n;
         #1;
         cnt = en ? cnt + 1 : 0;
         if (en && cnt >= int'(kick_period)) begin
            strobe_out = ~strobe_out;
            cnt        = 0;
         end
      end
   end
endmodule : psrw_cpu_model

/* psrw_pkg.sv */
// Shared constants for the processor supervisor, reset and watchdog block
package psrw_pkg;

   // ***************************************************************
   // Clock and documented times
   // ***************************************************************
   localparam int PSRW_CLK_HZ         = 125_000_000;
   localparam int PSRW_HZ_PER_KHZ     = 1000;
   localparam int PSRW_STRETCH_MS     = 200;   // Reset stretch, 200 ms
   localparam int PSRW_WDOG_MS        = 1600;  // Watchdog timeout, 1.6 s
   // Cycle counts derived from the rate
   localparam int PSRW_STRETCH_CYC    =
      (PSRW_CLK_HZ / PSRW_HZ_PER_KHZ) * PSRW_STRETCH_MS;
   localparam int PSRW_WDOG_CYC       =
      (PSRW_CLK_HZ / PSRW_HZ_PER_KHZ) * PSRW_WDOG_MS;
   localparam int PSRW_CNT_W          = 28;    // Holds 1.6 s of cycles

   // ***************************************************************
   // Synchroniser reset levels (safe side: supply assumed low)
   // ***************************************************************
   localparam logic PSRW_RST_SUPPLY_LOW = 1'b1;
   localparam logic PSRW_RST_MR_N       = 1'b1;
   localparam logic PSRW_RST_STROBE     = 1'b0;
   localparam logic PSRW_RST_FLOAT      = 1'b1;
   localparam logic PSRW_RST_PF_LOW     = 1'b0;

   // ***************************************************************
   // Supervisor reset sequencing
   // ***************************************************************
   typedef enum logic [1:0] {
      PSRW_HOLD    = 2'b00,   // A cause is present
      PSRW_STRETCH = 2'b01,   // Cause gone, timing the stretch
      PSRW_RUN     = 2'b10    // Reset released
   } psrw_state_t;

endpackage : psrw_pkg

/* psrw_sync.sv */
// Three-stage synchroniser; a change counts once stages two and three agree
module psrw_sync
   import psrw_pkg::*;
#(
   parameter logic RESET_VAL = 1'b0
) (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_n,
   // Asynchronous level in, filtered level out
   input  wire logic async_in,
   output      logic level_out
);

   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   // Stage one feeds only stage two
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg <= RESET_VAL;
         s2_reg <= RESET_VAL;
         s3_reg <= RESET_VAL;
      end else begin
         s1_reg <= async_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // Hold the level until the last two stages agree
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         level_out <= RESET_VAL;
      end else if (s2_reg == s3_reg) begin
         level_out <= s3_reg;
      end
   end

endmodule : psrw_sync

/* psrw_top.sv */
// Processor supervisor: reset generator, watchdog and power-fail flag
module psrw_top
   import psrw_pkg::*;
#(
   parameter int STRETCH_CYCLES = PSRW_STRETCH_CYC,
   parameter int WDOG_CYCLES    = PSRW_WDOG_CYC,
   parameter int CNT_W          = PSRW_CNT_W
) (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_n,
   // Comparator and pin inputs, all asynchronous
   input  wire logic supply_low_in,
   input  wire logic manual_reset_in_n,
   input  wire logic watchdog_strobe_in,
   input  wire logic watchdog_strobe_float_in,
   input  wire logic powerfail_sense_low_in,
   // Supervisor outputs
   output      logic reset_out_n,
   output      logic reset_out,
   output      logic watchdog_timeout_out_n,
   output      logic powerfail_flag_out_n
);

   // ***************************************************************
   // Input synchronisation
   // ***************************************************************
   logic supply_low_s;
   logic mr_n_s;
   logic strobe_s;
   logic float_s;
   logic pf_low_s;

   // Every level from outside the clock domain is filtered first
   psrw_sync #(.RESET_VAL(PSRW_RST_SUPPLY_LOW)) u_sync_supply (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .async_in  (supply_low_in),
      .level_out (supply_low_s)
   );
   psrw_sync #(.RESET_VAL(PSRW_RST_MR_N)) u_sync_mr (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .async_in  (manual_reset_in_n),
      .level_out (mr_n_s)
   );
   psrw_sync #(.RESET_VAL(PSRW_RST_STROBE)) u_sync_strobe (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .async_in  (watchdog_strobe_in),
      .level_out (strobe_s)
   );
   psrw_sync #(.RESET_VAL(PSRW_RST_FLOAT)) u_sync_float (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .async_in  (watchdog_strobe_float_in),
      .level_out (float_s)
   );
   psrw_sync #(.RESET_VAL(PSRW_RST_PF_LOW)) u_sync_pf (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .async_in  (powerfail_sense_low_in),
      .level_out (pf_low_s)
   );

   // ***************************************************************
   // Reset generation
   // ***************************************************************
   localparam logic [CNT_W-1:0] STRETCH_LAST = CNT_W'(STRETCH_CYCLES - 1);
   localparam logic [CNT_W-1:0] WDOG_LAST    = CNT_W'(WDOG_CYCLES);

   psrw_state_t      state_reg;
   psrw_state_t      state_next;
   logic [CNT_W-1:0] stretch_cnt_reg;
   logic             reset_cause;
   logic             reset_active;

   assign reset_cause  = supply_low_s | ~mr_n_s;
   assign reset_active = (state_reg != PSRW_RUN);

   // Any cause returns to hold, so bounce restarts the full stretch
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         PSRW_HOLD: begin
            if (!reset_cause) begin
               state_next = PSRW_STRETCH;
            end
         end
         PSRW_STRETCH: begin
            if (reset_cause) begin
               state_next = PSRW_HOLD;
            end else if (stretch_cnt_reg == STRETCH_LAST) begin
               state_next = PSRW_RUN;
            end
         end
         PSRW_RUN: begin
            if (reset_cause) begin
               state_next = PSRW_HOLD;
            end
         end
         default: begin
            state_next = PSRW_HOLD;
         end
      endcase
   end

   // Sequencer state
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= PSRW_HOLD;
      end else begin
         state_reg <= state_next;
      end
   end

   // Stretch timer runs only in the stretch state
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         stretch_cnt_reg <= '0;
      end else if (state_reg != PSRW_STRETCH || reset_cause) begin
         stretch_cnt_reg <= '0;
      end else begin
         stretch_cnt_reg <= stretch_cnt_reg + 1'b1;
      end
   end

   // Both polarities come from one next value so they never disagree
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reset_out_n <= 1'b0;
         reset_out   <= 1'b1;
      end else begin
         reset_out_n <= (state_next == PSRW_RUN);
         reset_out   <= (state_next != PSRW_RUN);
      end
   end

   // ***************************************************************
   // Watchdog
   // ***************************************************************
   logic             strobe_prev_reg;
   logic [CNT_W-1:0] wdog_cnt_reg;
   logic             strobe_edge;
   logic             wdog_clear;
   logic             wdog_expired;

   assign strobe_edge  = (strobe_s != strobe_prev_reg);
   assign wdog_clear   = strobe_edge | reset_active | float_s;
   assign wdog_expired = (wdog_cnt_reg == WDOG_LAST);

   // Previous strobe level for edge detection
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         strobe_prev_reg <= PSRW_RST_STROBE;
      end else begin
         strobe_prev_reg <= strobe_s;
      end
   end

   // Counter saturates, which keeps the timeout latched
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wdog_cnt_reg <= '0;
      end else if (wdog_clear) begin
         wdog_cnt_reg <= '0;
      end else if (!wdog_expired) begin
         wdog_cnt_reg <= wdog_cnt_reg + 1'b1;
      end
   end

   // Timeout output; it never feeds the reset sequencer
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         watchdog_timeout_out_n <= 1'b0;
      end else begin
         watchdog_timeout_out_n <= ~(supply_low_s |
                                     (wdog_expired & ~wdog_clear));
      end
   end

   // ***************************************************************
   // Power-fail flag
   // ***************************************************************
   // Plain follower of the synchronised comparator level
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         powerfail_flag_out_n <= 1'b1;
      end else begin
         powerfail_flag_out_n <= ~pf_low_s;
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence s_quiet_dog;
      !supply_low_s && !strobe_edge && !reset_active && !float_s;
   endsequence

   sequence s_mr_release;
      $rose(mr_n_s) && !supply_low_s;
   endsequence

   property p_supply_holds_reset;
      supply_low_s |=> !reset_out_n;
   endproperty
   a_supply_holds_reset: assert property (p_supply_holds_reset)
      else $error("reset released while supply low");

   property p_release_after_stretch;
      $rose(reset_out_n) |-> $past(state_reg) == PSRW_STRETCH &&
                             $past(stretch_cnt_reg) == STRETCH_LAST;
   endproperty
   a_release_after_stretch: assert property (p_release_after_stretch)
      else $error("reset released before stretch ended");

   property p_inverse;
      reset_out == !reset_out_n;
   endproperty
   a_inverse: assert property (p_inverse)
      else $error("reset outputs not complementary");

   property p_manual_reset;
      !mr_n_s |=> !reset_out_n;
   endproperty
   a_manual_reset: assert property (p_manual_reset)
      else $error("manual reset did not hold reset");

   // Both cycles must be quiet, or a clear in the first resets the count
   property p_wdog_expire;
      (wdog_cnt_reg == WDOG_LAST - 1'b1) ##0 s_quiet_dog ##1 s_quiet_dog
         |=> !watchdog_timeout_out_n;
   endproperty
   a_wdog_expire: assert property (p_wdog_expire)
      else $error("watchdog did not time out");

   property p_strobe_clears;
      strobe_edge |=> wdog_cnt_reg == '0 &&
                      watchdog_timeout_out_n == !$past(supply_low_s);
   endproperty
   a_strobe_clears: assert property (p_strobe_clears)
      else $error("strobe edge did not clear watchdog");

   property p_reset_clears;
      !reset_out_n |=> wdog_cnt_reg == '0;
   endproperty
   a_reset_clears: assert property (p_reset_clears)
      else $error("watchdog counted during reset");

   property p_lowline;
      supply_low_s |=> !watchdog_timeout_out_n;
   endproperty
   a_lowline: assert property (p_lowline)
      else $error("low supply did not force timeout low");

   property p_float;
      float_s && !supply_low_s |=> watchdog_timeout_out_n;
   endproperty
   a_float: assert property (p_float)
      else $error("floating strobe still timed out");

   property p_powerfail;
      1'b1 |=> powerfail_flag_out_n == !$past(pf_low_s);
   endproperty
   a_powerfail: assert property (p_powerfail)
      else $error("power-fail flag does not follow sense");

   property p_sticky;
      !watchdog_timeout_out_n ##0 s_quiet_dog |=> !watchdog_timeout_out_n;
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("timeout released without a clear");

   property p_mr_stretch;
      s_mr_release |-> !reset_out_n ##1 !reset_out_n;
   endproperty
   a_mr_stretch: assert property (p_mr_stretch)
      else $error("reset released at manual reset rise");

   property p_no_wdog_reset;
      reset_out_n && !watchdog_timeout_out_n && mr_n_s && !supply_low_s
         |=> reset_out_n;
   endproperty
   a_no_wdog_reset: assert property (p_no_wdog_reset)
      else $error("watchdog expiry asserted reset");

endmodule : psrw_top

/* psrw_top_tb.sv */
// Self-checking testbench for the supervisor, reset and watchdog block
module psrw_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int STR = 20;
   localparam int WDG = 50;
   logic       clk_sys    = 1'b0;
   logic       rst_n      = 1'b0;
   logic       supply_low = 1'b1;
   logic       mr_n       = 1'b1;
   logic       flt        = 1'b0;
   logic       pf         = 1'b0;
   logic       kick_en    = 1'b0;
   logic [7:0] kick_period = 8'h0a;
   logic       strobe;
   logic       rst_o_n;
   logic       rst_o;
   logic       wdo_n;
   logic       pfo_n;
   int         num_errors = 0;
   int         checked    = 0;
   int         cyc        = 0;
   int         last_kick  = 0;
   int         n;
   logic       pf_hist[$];

   // ***************************************************************
   // Clock, cycle count and kick tracking
   // ***************************************************************
   always #4 clk_sys = ~clk_sys;
   // Cycle stamp used to time outputs against the last strobe change
   always @(posedge clk_sys) cyc <= cyc + 1;
   always @(strobe) last_kick = cyc;

   psrw_top #(.STRETCH_CYCLES(STR), .WDOG_CYCLES(WDG)) dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .supply_low_in(supply_low),
      .manual_reset_in_n(mr_n), .watchdog_strobe_in(strobe),
      .watchdog_strobe_float_in(flt), .powerfail_sense_low_in(pf),
      .reset_out_n(rst_o_n), .reset_out(rst_o),
      .watchdog_timeout_out_n(wdo_n), .powerfail_flag_out_n(pfo_n));

   psrw_cpu_model cpu (
      .clk_sys(clk_sys), .reset_out_n(rst_o_n), .kick_en(kick_en),
      .kick_period(kick_period), .strobe_out(strobe));

   // ***************************************************************
   // Model, checks and helpers
   // ***************************************************************
   // Settled reset level from the supply and manual reset levels
   function automatic logic m_rst_n(int s, int m);
      return logic'(s == 0 && m != 0);
   endfunction : m_rst_n

   task automatic check(input logic seen, input logic exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: saw %b expected %b", $time, seen, exp);
      end
   endtask : check

   task automatic step(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask : step

   // Bounded wait for reset (sel 0) or timeout (sel 1) to reach a level
   task automatic wait_for(input int sel, input logic lvl, input int lim,
                           output int cnt);
      cnt = 0;
      while (((sel == 0) ? rst_o_n : wdo_n) !== lvl && cnt < lim) begin
         step(1);
         cnt++;
      end
   endtask : wait_for

   task automatic summarize();
      $display("Checks %0d, errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize

   // Complement is compared on every falling edge once out of reset
   always @(negedge clk_sys) begin
      if (rst_n) check(rst_o, ~rst_o_n);
   end

   // Reference model: the flag shows the sense level sampled four edges back
   always @(posedge clk_sys) begin
      pf_hist.push_back(pf);
      if (pf_hist.size() > 5) void'(pf_hist.pop_front());
   end
   always @(negedge clk_sys) begin
      if (pf_hist.size() == 5) check(pfo_n, ~pf_hist[0]);
   end

   // Watchdog: a hang here counts against the run
   initial begin
      step(6000);
      num_errors++;
      summarize();
   end

   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial begin
      void'($urandom(41));
      repeat (6) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      step(8);
      check(rst_o_n, m_rst_n(1, 1));
      check(wdo_n, 1'b0);
      supply_low = 1'b0;
      wait_for(0, 1'b1, STR + 20, n);
      check(n >= STR && n <= STR + 8, 1'b1);
      wait_for(1, 1'b0, WDG + 20, n);
      check(n >= WDG - 1 && n <= WDG + 4, 1'b1);
      check(rst_o_n, 1'b1);
      // Random kick periods all well inside the timeout
      kick_en = 1'b1;
      for (int i = 0; i < 4; i++) begin
         kick_period = 8'($urandom_range(WDG - 10, 2));
         step(150);
         check(wdo_n, 1'b1);
      end
      kick_en = 1'b0;
      wait_for(1, 1'b0, WDG + 40, n);
      n = cyc - last_kick;
      check(n >= WDG && n <= WDG + 8, 1'b1);
      step(100);
      check(wdo_n, 1'b0);
      check(rst_o_n, 1'b1);
      // Exactly one strobe edge must clear an expired timeout
      kick_period = 8'h01;
      kick_en     = 1'b1;
      step(1);
      kick_en = 1'b0;
      wait_for(1, 1'b1, 10, n);
      check(wdo_n, 1'b1);
      // Manual reset with bounce shorter than the stretch
      mr_n = 1'b0;
      step(10);
      check(rst_o_n, m_rst_n(0, 0));
      // Alternate levels so no high phase outlasts the stretch
      for (int i = 0; i < 5; i++) begin
         mr_n = ~mr_n;
         step($urandom_range(STR - 4, 1));
         check(rst_o_n, 1'b0);
      end
      mr_n = 1'b0;
      step(6);
      mr_n = 1'b1;
      wait_for(0, 1'b1, STR + 20, n);
      check(n >= STR && n <= STR + 8, 1'b1);
      // Floating strobe: only low supply may pull the timeout low
      flt = 1'b1;
      step(3 * WDG);
      check(wdo_n, 1'b1);
      supply_low = 1'b1;
      step(8);
      check(wdo_n, 1'b0);
      check(rst_o_n, m_rst_n(1, 1));
      supply_low = 1'b0;
      step(STR + 10);
      check(rst_o_n, m_rst_n(0, 1));
      check(wdo_n, 1'b1);
      // Power-fail flag follows random sense levels
      for (int i = 0; i < 8; i++) begin
         pf = logic'($urandom_range(1, 0));
         step(8);
         check(pfo_n, ~pf);
      end
      summarize();
   end
endmodule : psrw_top_tb
